/* hdl/idt_pkg.sv */
// shared constants and types for the input delay tap control block
package idt_pkg;
    localparam int TAP_W = 9;
    localparam int DATA_W = 32;
    localparam int SYNC_STAGES = 2;
    localparam logic [TAP_W-1:0] INIT_TAP_RST = 9'h000;
    localparam logic [TAP_W-1:0] JUMP_MAX = 9'h008;

    // settle time of a new tap, in control clock cycles
    localparam int SETTLE_CYC = 3;
    localparam logic [1:0] SETTLE_LOAD = 2'(SETTLE_CYC);

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INIT = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_STEPS = 8'h0c;

    // control register fields
    localparam int CTRL_TYPE_LSB = 0;
    localparam int CTRL_SRC_BIT = 2;
    localparam int CTRL_UMODE_LSB = 3;

    // status register fields
    localparam int ST_SETTLE_BIT = 12;
    localparam int ST_COMP_BIT = 13;
    localparam int ST_ERR_LOADSTEP_BIT = 16;
    localparam int ST_ERR_COMP_BIT = 17;
    localparam int ST_ERR_JUMP_BIT = 18;

    typedef enum logic [1:0] {
        DT_STATIC = 2'b00,
        DT_STEPPING = 2'b01,
        DT_STEP_LOAD = 2'b10
    } idt_dtype_t;

    typedef enum logic [1:0] {
        UM_ASYNC = 2'b00,
        UM_SYNC = 2'b01,
        UM_MANUAL = 2'b10
    } idt_umode_t;

    localparam logic SRC_PAD = 1'b0;
    localparam logic SRC_FABRIC = 1'b1;
endpackage

/* hdl/idt_sync.sv */
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module idt_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    import idt_pkg::*;

    logic [WIDTH-1:0] meta_r;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gBit
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_r[g] <= 1'b0;
                    syncOut[g] <= 1'b0;
                end else begin
                    meta_r[g] <= asyncIn[g];
                    syncOut[g] <= meta_r[g];
                end
            end
        end
    endgenerate
endmodule

/* hdl/idt_delay_mem.sv */
// circular delay line memory with registered read data
`timescale 1ns/1ps
module idt_delay_mem #(
    parameter int WIDTH = 1,
    parameter int AW = 9
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    import idt_pkg::*;

    // no reset on the array so it maps onto plain storage
    logic [WIDTH-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        mem[wrAddr] <= wrData;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData <= '0;
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule

/* hdl/idt_tap_delay.sv */
// input delay tap control: register slave, tap counter and delay line
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
// Function
// - load, step enable and direction sampled only on rising control clock edges
// - stepping works only in stepping or step-load mode
// - step enable high moves the tap by one each cycle, direction picks up/down
// - step enable low leaves the tap unchanged whatever the direction
// - stepping starts and stops on the first edge after step enable changes
// - tap wraps from last to zero and from zero to last
// - load sets tap from initial value or from the tap input bus
// - in step-load mode with async update, load takes the nine-bit tap input
// - load is active high and synchronous to the control clock
// - a new tap may take up to three cycles to apply
// - current tap count is always reported on a nine-bit output
// - with compensation on, reported tap follows calibration updates; here only in stepping or step-load mode, static keeps the initial tap
// - fabric data goes through the line back to fabric, never to a pad
// - delayed output carries the selected pad or fabric input
// - asynchronous reset sets the tap to the initial value
// - compensation on holds delay over voltage and temperature; off, none
// - initial value in count format is a tap count 0 to 511
// - delay type selects static, stepping or step-load, static by default
// - source setting picks pad input or fabric input
module idt_tap_delay #(
    parameter int TAP_W = idt_pkg::TAP_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [idt_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [idt_pkg::DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic loadTap,
    input wire logic stepEnable,
    input wire logic stepUp,
    input wire logic [TAP_W-1:0] tapValueIn,
    input wire logic compensationEnable,
    input wire logic calTapValid,
    input wire logic [TAP_W-1:0] calTapValue,
    input wire logic padDataIn,
    input wire logic fabricDataIn,
    output logic delayedDataOut,
    output logic [TAP_W-1:0] tapValueOut
);
    import idt_pkg::*;

    // configuration and state
    idt_dtype_t delayType_r;
    idt_umode_t updateMode_r;
    logic sourceSel_r;
    logic [TAP_W-1:0] initTap_r;
    logic [TAP_W-1:0] tap_r;
    logic [TAP_W-1:0] tapNxt;
    logic [TAP_W-1:0] appliedTap_r;
    logic [TAP_W-1:0] wrPtr_r;
    logic [1:0] settle_r;
    logic [15:0] steps_r;
    logic errLoadStep_r;
    logic errComp_r;
    logic errJump_r;

    // bus side
    logic wrPend_r;
    logic [7:0] wrAddr_r;
    logic rdReq;
    logic wrReq;
    logic wrCtrl;
    logic wrInit;
    logic wrStatus;
    logic wrSteps;

    // synchronised pins and decoded operations
    logic [1:0] syncIn;
    logic [1:0] syncOut;
    logic padSync;
    logic compSync;
    logic canStep;
    logic loadOk;
    logic doLoad;
    logic doStep;
    logic doCal;
    logic lineBit;
    logic [TAP_W-1:0] loadValue;

    // circular distance between two taps, either direction
    function automatic logic [TAP_W-1:0] tapDistance(
        input logic [TAP_W-1:0] a,
        input logic [TAP_W-1:0] b
    );
        logic [TAP_W-1:0] fwd;
        logic [TAP_W-1:0] bwd;
        fwd = TAP_W'(a - b);
        bwd = TAP_W'(b - a);
        return (fwd < bwd) ? fwd : bwd;
    endfunction

    // assembles the word seen by a read at the given offset
    function automatic logic [DATA_W-1:0] readWord(input logic [7:0] addr);
        logic [DATA_W-1:0] w;
        w = '0;
        unique case (addr)
            ADDR_CTRL: begin
                w[CTRL_TYPE_LSB +: 2] = delayType_r;
                w[CTRL_SRC_BIT] = sourceSel_r;
                w[CTRL_UMODE_LSB +: 2] = updateMode_r;
            end
            ADDR_INIT: begin
                w[TAP_W-1:0] = initTap_r;
            end
            ADDR_STATUS: begin
                w[TAP_W-1:0] = tap_r;
                w[ST_SETTLE_BIT] = (settle_r != 2'h0);
                w[ST_COMP_BIT] = compSync;
                w[ST_ERR_LOADSTEP_BIT] = errLoadStep_r;
                w[ST_ERR_COMP_BIT] = errComp_r;
                w[ST_ERR_JUMP_BIT] = errJump_r;
            end
            ADDR_STEPS: begin
                w[15:0] = steps_r;
            end
            default: begin
                w = '0;
            end
        endcase
        return w;
    endfunction

    // pad data and compensation enable come from outside the clock domain
    assign syncIn = {compensationEnable, padDataIn};

    idt_sync #(
        .WIDTH(2)
    ) uSync (
        .clk(clk),
        .arst_n(arst_n),
        .asyncIn(syncIn),
        .syncOut(syncOut)
    );

    assign padSync = syncOut[0];
    assign compSync = syncOut[1];

    // AHB-Lite slave: zero wait states, always OKAY
    assign rdReq = hsel & hready & htrans[1] & ~hwrite;
    assign wrReq = hsel & hready & htrans[1] & hwrite;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
        end else if (hready) begin
            wrPend_r <= wrReq;
            wrAddr_r <= {haddr[7:2], 2'b00};
        end
    end

    // read data registered at the address phase edge, stands in the data phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= '0;
        end else if (rdReq) begin
            hrdata <= readWord({haddr[7:2], 2'b00});
        end
    end

    assign wrCtrl = wrPend_r && (wrAddr_r == ADDR_CTRL);
    assign wrInit = wrPend_r && (wrAddr_r == ADDR_INIT);
    assign wrStatus = wrPend_r && (wrAddr_r == ADDR_STATUS);
    assign wrSteps = wrPend_r && (wrAddr_r == ADDR_STEPS);

    // illegal type or mode codes fall back to the safe default
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            delayType_r <= DT_STATIC;
            updateMode_r <= UM_ASYNC;
            sourceSel_r <= SRC_PAD;
        end else if (wrCtrl) begin
            unique case (hwdata[CTRL_TYPE_LSB +: 2])
                DT_STEPPING: delayType_r <= DT_STEPPING;
                DT_STEP_LOAD: delayType_r <= DT_STEP_LOAD;
                default: delayType_r <= DT_STATIC;
            endcase
            unique case (hwdata[CTRL_UMODE_LSB +: 2])
                UM_SYNC: updateMode_r <= UM_SYNC;
                UM_MANUAL: updateMode_r <= UM_MANUAL;
                default: updateMode_r <= UM_ASYNC;
            endcase
            sourceSel_r <= hwdata[CTRL_SRC_BIT];
        end
    end

    // nine-bit field holds every count 0 to 511
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            initTap_r <= INIT_TAP_RST;
        end else if (wrInit) begin
            initTap_r <= hwdata[TAP_W-1:0];
        end
    end

    // fabric control is same-clock logic, read directly on each edge
    assign canStep = (delayType_r == DT_STEPPING) || (delayType_r == DT_STEP_LOAD);
    // loads are refused in synchronous update mode, where the pin is tied low
    assign loadOk = canStep && (updateMode_r != UM_SYNC);
    assign doCal = canStep && compSync && calTapValid;
    assign doLoad = loadOk && loadTap && !doCal;
    assign doStep = canStep && stepEnable && !loadTap && !doCal;
    // step-load mode takes the bus, stepping mode reloads the initial tap
    assign loadValue = (delayType_r == DT_STEP_LOAD) ? tapValueIn : initTap_r;

    always_comb begin
        tapNxt = tap_r;
        if (!canStep) begin
            tapNxt = initTap_r;
        end else if (doCal) begin
            tapNxt = calTapValue;
        end else if (doLoad) begin
            tapNxt = loadValue;
        end else if (doStep) begin
            // natural nine-bit roll-over gives the wrap in both directions
            if (stepUp) begin
                tapNxt = TAP_W'(tap_r + 1'b1);
            end else begin
                tapNxt = TAP_W'(tap_r - 1'b1);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tap_r <= INIT_TAP_RST;
        end else begin
            tap_r <= tapNxt;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tapValueOut <= INIT_TAP_RST;
        end else begin
            tapValueOut <= tapNxt;
        end
    end

    // settle window: tap change reaches the line within three cycles
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_r <= 2'h0;
        end else if (tapNxt != tap_r) begin
            settle_r <= SETTLE_LOAD;
        end else if (settle_r != 2'h0) begin
            settle_r <= settle_r - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            appliedTap_r <= INIT_TAP_RST;
        end else begin
            appliedTap_r <= tap_r;
        end
    end

    // count of single steps taken, cleared by a write to the steps offset; a step in the same cycle wins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            steps_r <= 16'h0000;
        end else if (doStep) begin
            steps_r <= 16'(steps_r + 1'b1);
        end else if (wrSteps) begin
            steps_r <= 16'h0000;
        end
    end

    // sticky misuse flags; write one clears, a new event wins over the clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            errLoadStep_r <= 1'b0;
        end else if (loadOk && loadTap && stepEnable) begin
            errLoadStep_r <= 1'b1;
        end else if (wrStatus && hwdata[ST_ERR_LOADSTEP_BIT]) begin
            errLoadStep_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            errComp_r <= 1'b0;
        end else if (canStep && compSync && (loadTap || stepEnable)) begin
            errComp_r <= 1'b1;
        end else if (wrStatus && hwdata[ST_ERR_COMP_BIT]) begin
            errComp_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            errJump_r <= 1'b0;
        end else if (doLoad && (tapDistance(loadValue, tap_r) > JUMP_MAX)) begin
            errJump_r <= 1'b1;
        end else if (wrStatus && hwdata[ST_ERR_JUMP_BIT]) begin
            errJump_r <= 1'b0;
        end
    end

    // delay line: one sample per cycle, read back appliedTap cycles later
    assign lineBit = (sourceSel_r == SRC_FABRIC) ? fabricDataIn : padSync;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_r <= '0;
        end else begin
            wrPtr_r <= TAP_W'(wrPtr_r + 1'b1);
        end
    end

    // result returns to fabric only; there is no pad-side output
    idt_delay_mem #(
        .WIDTH(1),
        .AW(TAP_W)
    ) uLine (
        .clk(clk),
        .arst_n(arst_n),
        .wrAddr(wrPtr_r),
        .wrData(lineBit),
        .rdAddr(TAP_W'(wrPtr_r - appliedTap_r)),
        .rdData(delayedDataOut)
    );
endmodule

/* test/idt_checker.sv */
// port assertions for the input delay tap control block
`timescale 1ns/1ps
module idt_checker
    import idt_pkg::*;
#(
    parameter int TAP_W = idt_pkg::TAP_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [idt_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    input wire logic loadTap,
    input wire logic stepEnable,
    input wire logic stepUp,
    input wire logic [TAP_W-1:0] tapValueIn,
    input wire logic compensationEnable,
    input wire logic calTapValid,
    input wire logic [TAP_W-1:0] calTapValue,
    input wire logic [TAP_W-1:0] tapValueOut
);
    logic wrPend_r;
    logic [5:0] wrIdx_r;
    logic [1:0] type_r;
    logic [1:0] umode_r;
    logic [TAP_W-1:0] init_r;
    logic [2:0] compHist_r;
    logic quiet, stepping, loadsBus;
    // three quiet samples cover the two-flop sync of the compensation level
    assign quiet = compHist_r == 3'h0 && !compensationEnable && !calTapValid;
    assign stepping = type_r == DT_STEPPING || type_r == DT_STEP_LOAD;
    assign loadsBus = type_r == DT_STEP_LOAD && umode_r != UM_SYNC;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPend_r <= 1'b0;
            wrIdx_r <= 6'h00;
        end else begin
            wrPend_r <= hsel && hready && htrans[1] && hwrite;
            wrIdx_r <= haddr[7:2];
        end
    end
    // shadow of the mode and initial tap registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            type_r <= 2'h0;
            umode_r <= 2'h0;
            init_r <= INIT_TAP_RST;
        end else if (wrPend_r && wrIdx_r == ADDR_CTRL[7:2]) begin
            type_r <= hwdata[1:0];
            umode_r <= hwdata[4:3];
        end else if (wrPend_r && wrIdx_r == ADDR_INIT[7:2]) begin
            init_r <= hwdata[TAP_W-1:0];
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            compHist_r <= 3'h0;
        end else begin
            compHist_r <= {compHist_r[1:0], compensationEnable};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    step_up_a: assert property (
        quiet && stepping && stepEnable && stepUp && !loadTap |=> tapValueOut == $past(tapValueOut) + 9'h001)
        else $error("tap did not rise by one");
    step_down_a: assert property (
        quiet && stepping && stepEnable && !stepUp && !loadTap |=> tapValueOut == $past(tapValueOut) - 9'h001)
        else $error("tap did not fall by one");
    tap_hold_a: assert property (
        quiet && stepping && !stepEnable && !loadTap |=> $stable(tapValueOut))
        else $error("tap moved without step enable");
    load_init_a: assert property (
        quiet && type_r == DT_STEPPING && loadTap |=> tapValueOut == $past(init_r))
        else $error("load did not take the initial tap");
    load_bus_a: assert property (
        quiet && loadsBus && loadTap |=> tapValueOut == $past(tapValueIn))
        else $error("load did not take the tap input");
    cal_update_a: assert property (
        compHist_r == 3'h7 && compensationEnable && calTapValid |=> tapValueOut == $past(calTapValue))
        else $error("calibration tap not reported");
    static_keep_a: assert property (
        quiet && !stepping |=> tapValueOut == $past(init_r))
        else $error("static tap left the initial value");
    reset_tap_a: assert property (
        $rose(arst_n) |-> tapValueOut == INIT_TAP_RST)
        else $error("tap not at reset value");
    cover property (stepping && stepEnable && stepUp);
    cover property (loadsBus && loadTap);
    cover property (compHist_r == 3'h7 && calTapValid);
endmodule

bind idt_tap_delay idt_checker #(.TAP_W(TAP_W)) idt_checker_inst (
    .clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .loadTap, .stepEnable, .stepUp,
    .tapValueIn, .compensationEnable, .calTapValid, .calTapValue, .tapValueOut
);

/* test/idt_fabric_model.sv */
// fabric control logic and calibration controller driving the tap pins
`timescale 1ns/1ps
module idt_fabric_model (
    input wire logic clk, // shares the bench clock with the block
    output logic loadTap,
    output logic stepEnable,
    output logic stepUp,
    output logic [8:0] tapValueIn,
    output logic compensationEnable,
    output logic calTapValid,
    output logic [8:0] calTapValue
);
    initial begin
        loadTap = 1'b0;
        stepEnable = 1'b0;
        stepUp = 1'b0;
        tapValueIn = 9'h000;
        compensationEnable = 1'b0;
        calTapValid = 1'b0;
        calTapValue = 9'h000;
    end
    task automatic step(input logic up, input int n);
        @(posedge clk);
        stepEnable <= 1'b1; // compensation is already low here
        stepUp <= up;
        repeat (n) @(posedge clk);
        stepEnable <= 1'b0;
        stepUp <= ~up; // direction wanders once the enable drops
    endtask
    // never used in sync update mode, so load stays low there
    task automatic load(input logic [8:0] v);
        @(posedge clk);
        tapValueIn <= v;
        @(posedge clk);
        loadTap <= 1'b1;
        @(posedge clk);
        loadTap <= 1'b0;
        tapValueIn <= ~v;
    endtask
    // waits out the sync of the enable before the pulse, and after dropping it
    task automatic cal(input logic [8:0] v);
        @(posedge clk);
        compensationEnable <= 1'b1;
        repeat (4) @(posedge clk);
        calTapValid <= 1'b1;
        calTapValue <= v;
        @(posedge clk);
        calTapValid <= 1'b0;
        calTapValue <= ~v;
        compensationEnable <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule

/* test/idt_tap_delay_test.sv */
// self-checking bench for the input delay tap control block
`timescale 1ns/1ps
module idt_tap_delay_test;
    import idt_pkg::*;
    logic clk, arst_n, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic loadTap, stepEnable, stepUp, compensationEnable, calTapValid;
    logic padDataIn, fabricDataIn, delayedDataOut;
    logic [8:0] tapValueIn, calTapValue, tapValueOut;
    int num_errors = 0;
    int checked = 0;

    idt_tap_delay idt_tap_delay_inst (
        .clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .loadTap, .stepEnable, .stepUp, .tapValueIn, .compensationEnable, .calTapValid,
        .calTapValue, .padDataIn, .fabricDataIn, .delayedDataOut, .tapValueOut
    );
    idt_fabric_model idt_fabric_model_inst (
        .clk, .loadTap, .stepEnable, .stepUp, .tapValueIn, .compensationEnable, .calTapValid, .calTapValue
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one single-word transfer; read data is taken at the data-phase edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk("bus response", 32'h00000000, {31'h00000000, hresp});
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h00000000, q);
        chk(what, exp, q);
    endtask
    // lets a new tap settle, then checks the pins and the status word
    task automatic tapchk(input string what, input logic [8:0] exp);
        repeat (3) @(posedge clk);
        #1;
        chk(what, {23'h000000, exp}, {23'h000000, tapValueOut});
        xfer(1'b0, ADDR_STATUS, 32'h00000000, q);
        chk(what, {23'h000000, exp}, {23'h000000, q[8:0]});
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end

    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h00000000;
        padDataIn = 1'b0;
        fabricDataIn = 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rdchk("ctrl reset", ADDR_CTRL, 32'h00000000);
        rdchk("unmapped read", 8'h10, 32'h00000000);
        tapchk("reset tap", 9'h000);
        $display("test reset done");
        xfer(1'b1, ADDR_INIT, 32'h00000005, q);
        idt_fabric_model_inst.step(1'b1, 3);
        idt_fabric_model_inst.load(9'h006);
        tapchk("static tap", 9'h005);
        $display("test static done");
        xfer(1'b1, ADDR_CTRL, 32'h00000001, q);
        idt_fabric_model_inst.step(1'b1, 3);
        tapchk("step up", 9'h008);
        idt_fabric_model_inst.step(1'b0, 2);
        tapchk("step down", 9'h006);
        // bus value is ignored here, stepping mode reloads the initial tap
        idt_fabric_model_inst.load(9'h1ff);
        tapchk("load initial", 9'h005);
        xfer(1'b1, ADDR_INIT, 32'h00000000, q);
        idt_fabric_model_inst.load(9'h003);
        tapchk("load zero", 9'h000);
        idt_fabric_model_inst.step(1'b0, 1);
        tapchk("wrap down", 9'h1ff);
        idt_fabric_model_inst.step(1'b1, 1);
        tapchk("wrap up", 9'h000);
        $display("test stepping done");
        xfer(1'b1, ADDR_CTRL, 32'h00000002, q);
        idt_fabric_model_inst.load(9'h008);
        tapchk("load bus", 9'h008);
        idt_fabric_model_inst.step(1'b1, 2);
        idt_fabric_model_inst.load(9'h003);
        tapchk("reload bus", 9'h003);
        // static-mode steps are ignored, so only the seven stepping-mode and two step-load-mode steps count
        rdchk("step count", ADDR_STEPS, 32'h00000009);
        $display("test step load done");
        idt_fabric_model_inst.cal(9'h123);
        tapchk("calibrated tap", 9'h123);
        $display("test calibration done");
        // a full lap of the line flushes the unwritten contents
        fabricDataIn <= 1'b1;
        xfer(1'b1, ADDR_CTRL, 32'h00000016, q);
        rdchk("ctrl fabric manual", ADDR_CTRL, 32'h00000016);
        repeat (600) @(posedge clk);
        #1;
        chk("fabric path", 32'h00000001, {31'h00000000, delayedDataOut});
        // opposite levels on the two inputs, so a wrong source shows up
        padDataIn <= 1'b1;
        fabricDataIn <= 1'b0;
        xfer(1'b1, ADDR_CTRL, 32'h0000000a, q);
        rdchk("ctrl pad sync", ADDR_CTRL, 32'h0000000a);
        repeat (600) @(posedge clk);
        #1;
        chk("pad path", 32'h00000001, {31'h00000000, delayedDataOut});
        $display("test source done");
        end_of_test();
    end
endmodule
